/* File: common/fwp_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Synchronised link events passed from the front end to the protection core.
interface fwp_link_if;
	logic frame_start;
	logic byte_valid;
	logic [7:0] byte_data;
	logic frame_end;
	logic [7:0] out_byte;
	modport front (output frame_start, output byte_valid, output byte_data,
		output frame_end, input out_byte);
	modport core (input frame_start, input byte_valid, input byte_data,
		input frame_end, output out_byte);
endinterface
`default_nettype wire

/* File: common/fwp_pkg.sv */
package fwp_pkg;

	// ----------------------------------------------------------------
	// Command codes seen on the serial link.
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_READ_STATUS = 8'h05;
	localparam logic [7:0] CMD_READ_FUNCTION = 8'h48;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_QUAD_PROGRAM_A = 8'h32;
	localparam logic [7:0] CMD_QUAD_PROGRAM_B = 8'h38;
	localparam logic [7:0] CMD_SECTOR_ERASE_A = 8'hd7;
	localparam logic [7:0] CMD_SECTOR_ERASE_B = 8'h20;
	localparam logic [7:0] CMD_BLOCK_ERASE_32K = 8'h52;
	localparam logic [7:0] CMD_BLOCK_ERASE_64K = 8'hd8;
	localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_FUNCTION_WRITE = 8'h42;
	localparam logic [7:0] CMD_INFO_ROW_ERASE = 8'h64;
	localparam logic [7:0] CMD_INFO_ROW_PROGRAM = 8'h62;
	localparam logic [7:0] CMD_SUSPEND = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7a;

	// ----------------------------------------------------------------
	// Status register field positions.
	// ----------------------------------------------------------------
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_QE = 6;
	localparam int ST_STATUS_WRITE_DISABLE = 7;
	localparam logic [7:0] STATUS_NV_MASK = 8'hfc;

	// ----------------------------------------------------------------
	// Function register field positions.
	// ----------------------------------------------------------------
	localparam int FN_TBS = 1;
	localparam int FN_PROGRAM_SUSPENDED_FLAG = 2;
	localparam int FN_ERASE_SUSPENDED_FLAG = 3;
	localparam int FN_IRL_LO = 4;
	localparam logic [7:0] FUNCTION_OTP_MASK = 8'hf2;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Address layout and block-protection geometry.
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int BLOCK_SHIFT = 16;
	localparam int INFO_ROW_SHIFT = 12;
	localparam int BLOCKS_DEFAULT = 128;

	// ----------------------------------------------------------------
	// Array operation timing (in microseconds of busy time).
	// ----------------------------------------------------------------
	localparam int OP_TIME_US = 10;
	localparam int CLK_MHZ = 200;
	localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;

	// Kind of array operation in flight.
	typedef enum logic [1:0] {
		FWP_OP_NONE,
		FWP_OP_PROGRAM,
		FWP_OP_ERASE,
		FWP_OP_REGISTER
	} fwp_op_t;

endpackage

/* File: core/fwp_link_rx.sv */
`timescale 1ns/100ps
`default_nettype none
// Samples the serial pins on the system clock and frames bytes.
module fwp_link_rx
	import fwp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	fwp_link_if.front link
);

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sck_s; // Synchroniser for the serial clock.
		logic [1:0] cs_s; // Synchroniser for chip select.
		logic [1:0] si_s; // Synchroniser for data in.
		logic sck_d; // Last synchronised clock level.
		logic cs_d; // Last synchronised select level.
		logic [2:0] bit_cnt; // Bits gathered in this byte.
		logic [7:0] shift; // Incoming byte.
		logic [7:0] tx; // Outgoing byte.
		logic start; // Frame start pulse.
		logic valid; // Byte complete pulse.
		logic stop; // Frame end pulse.
		logic so; // Data out level.
	} fwp_rx_t;

	fwp_rx_t st;
	fwp_rx_t next_st;

	// ----------------------------------------------------------------
	// Next-state logic; bits are taken on rising edges, shifted out on falling.
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.sck_s = {st.sck_s[0], sck_i};
		next_st.cs_s = {st.cs_s[0], cs_n_i};
		next_st.si_s = {st.si_s[0], si_i};
		next_st.sck_d = st.sck_s[1];
		next_st.cs_d = st.cs_s[1];
		next_st.start = st.cs_d && !st.cs_s[1];
		next_st.stop = !st.cs_d && st.cs_s[1];
		next_st.valid = 1'b0;
		if (st.cs_s[1]) begin
			// Deselected: the next frame starts on a byte boundary.
			next_st.bit_cnt = 3'd0;
		end else if (!st.sck_d && st.sck_s[1]) begin
			next_st.shift = {st.shift[6:0], st.si_s[1]};
			next_st.bit_cnt = st.bit_cnt + 3'd1;
			if (st.bit_cnt == 3'd7) begin
				next_st.valid = 1'b1;
			end
		end else if (st.sck_d && !st.sck_s[1]) begin
			next_st.so = st.tx[3'd7 - st.bit_cnt];
		end
		// Reload the reply while the finished byte is offered to the core, so the
		// opcode of this very frame already decides which image is sent back.
		if (st.valid) begin
			next_st.tx = link.out_byte;
		end
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{sck_s: 2'b00, cs_s: 2'b11, si_s: 2'b00, sck_d: 1'b0,
				cs_d: 1'b1, bit_cnt: 3'd0, shift: 8'h00, tx: 8'h00,
				start: 1'b0, valid: 1'b0, stop: 1'b0, so: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign link.frame_start = st.start;
	assign link.byte_valid = st.valid;
	assign link.byte_data = st.shift;
	assign link.frame_end = st.stop;
	assign so_o = st.so;

endmodule
`default_nettype wire

/* File: core/fwp_protect.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Write enable must precede every write command.
// - Refuse program or erase in protected area.
// - Chip erase only when protect bits zero.
// - Locked status register ignores status writes.
// - Status write accepted when unlocked or pin high.
// - Quad enable repurposes protect and hold pins; code ignores only hold, the protect pin still unlocks status writes.
// - 128-block map: 2^(n-1) blocks, top or bottom.
// - 64-block map; code 7, top bit all.
// - Top/bottom select sticks once set.
// - One-time bits never clear again.
// - Program suspend sets flag, resume clears.
// - Erase suspend sets flag, resume clears.
// - Locked information row refuses programming.
// - Latch set, cleared, auto-clears after writes.
// - Protect, quad, disable bits: status write only.
module fwp_protect
	import fwp_pkg::*;
#(
	parameter int BLOCKS = BLOCKS_DEFAULT,
	parameter int OP_CYCLES_P = OP_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	input wire logic wp_pin_i,
	input wire logic hold_pin_i,
	output logic quad_mode_o,
	output logic hold_active_o,
	output logic busy_o,
	output logic [7:0] status_o,
	output logic [7:0] function_config_register_o,
	output logic array_start_o,
	output fwp_op_t array_op_o,
	output logic [ADDR_W-1:0] array_addr_o,
	output logic array_chip_o
);

	// ----------------------------------------------------------------
	// Elaboration checks.
	// ----------------------------------------------------------------
	// Only the two documented densities have a protection map.
	if (BLOCKS != 64 && BLOCKS != 128) begin : g_bad_blocks
		$error("BLOCKS must be 64 or 128");
	end
	// A zero-length busy time would leave the countdown without a last value.
	if (OP_CYCLES_P < 1) begin : g_bad_cycles
		$error("OP_CYCLES_P must be at least one");
	end

	localparam int CNT_W = $clog2(OP_CYCLES_P + 1);
	localparam logic [CNT_W-1:0] OP_LAST = CNT_W'(OP_CYCLES_P - 1);

	fwp_link_if link();

	fwp_link_rx u_rx (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.sck_i(sck_i),
		.cs_n_i(cs_n_i),
		.si_i(si_i),
		.so_o(so_o),
		.link(link)
	);

	// ----------------------------------------------------------------
	// Pin synchronisers live in the state struct; the first stage is read
	// only by the second.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] wp_s; // Protect pin synchroniser.
		logic [1:0] hold_s; // Hold pin synchroniser.
		logic [7:0] status; // Status register image.
		logic [7:0] func; // Function register image.
		logic [7:0] cmd; // Command byte of this frame.
		logic [2:0] nbytes; // Bytes seen in this frame, saturating.
		logic [ADDR_W-1:0] addr; // Address gathered from the frame.
		logic [7:0] data; // First data byte after the opcode.
		fwp_op_t op; // Operation in flight.
		logic [CNT_W-1:0] cnt; // Busy countdown.
		logic suspended; // Operation paused.
		logic start; // Array start pulse.
		logic chip; // Operation covers the whole array.
	} fwp_st_t;

	fwp_st_t st;
	fwp_st_t next_st;

	// ----------------------------------------------------------------
	// Helper: is the block of this address inside the protected area.
	// ----------------------------------------------------------------
	function automatic logic block_protected(input logic [3:0] bp, input logic bottom,
		input logic [ADDR_W-1:0] a);
		int blk;
		int n;
		blk = int'(a >> BLOCK_SHIFT) % BLOCKS;
		if (bp == 4'h0) begin
			return 1'b0;
		end
		if (bp[3]) begin
			return 1'b1;
		end
		n = 1 << (int'(bp[2:0]) - 1);
		if (n > BLOCKS) begin
			n = BLOCKS;
		end
		if (bottom) begin
			return blk < n;
		end
		return blk >= BLOCKS - n;
	endfunction

	function automatic logic is_addr_cmd(input logic [7:0] c);
		return c == CMD_PAGE_PROGRAM || c == CMD_QUAD_PROGRAM_A || c == CMD_QUAD_PROGRAM_B
			|| c == CMD_SECTOR_ERASE_A || c == CMD_SECTOR_ERASE_B
			|| c == CMD_BLOCK_ERASE_32K || c == CMD_BLOCK_ERASE_64K
			|| c == CMD_INFO_ROW_ERASE || c == CMD_INFO_ROW_PROGRAM;
	endfunction

	// ----------------------------------------------------------------
	// Command decode and protection; all checks are made at frame end,
	// before anything is started, so a refusal leaves no trace.
	// ----------------------------------------------------------------
	always_comb begin
		logic wp_high;
		logic write_enable_latch;
		logic [3:0] bp;
		logic [1:0] row;
		logic [7:0] newf;
		wp_high = st.wp_s[1];
		write_enable_latch = st.status[ST_WEL];
		bp = st.status[ST_BP_LO +: 4];
		row = st.addr[INFO_ROW_SHIFT +: 2];
		newf = st.func;
		next_st = st;
		next_st.wp_s = {st.wp_s[0], wp_pin_i};
		next_st.hold_s = {st.hold_s[0], hold_pin_i};
		next_st.start = 1'b0;
		if (link.frame_start) begin
			next_st.nbytes = 3'd0;
		end
		if (link.byte_valid) begin
			if (st.nbytes == 3'd0) begin
				next_st.cmd = link.byte_data;
			end else if (st.nbytes == 3'd1) begin
				next_st.data = link.byte_data;
			end
			if (st.nbytes >= 3'd1 && st.nbytes <= 3'd3) begin
				next_st.addr = {st.addr[ADDR_W-9:0], link.byte_data};
			end
			if (st.nbytes != 3'd7) begin
				next_st.nbytes = st.nbytes + 3'd1;
			end
		end
		// Busy countdown; a completed write clears the latch.
		if (st.op != FWP_OP_NONE && !st.suspended) begin
			if (st.cnt == '0) begin
				next_st.op = FWP_OP_NONE;
				next_st.status[ST_WEL] = 1'b0;
			end else begin
				next_st.cnt = st.cnt - 1'b1;
			end
		end
		if (link.frame_end && st.nbytes != 3'd0) begin
			case (st.cmd)
				CMD_WRITE_ENABLE: begin
					if (st.op == FWP_OP_NONE || st.suspended) begin
						next_st.status[ST_WEL] = 1'b1;
					end
				end
				CMD_WRITE_DISABLE: begin
					if (st.op == FWP_OP_NONE || st.suspended) begin
						next_st.status[ST_WEL] = 1'b0;
					end
				end
				CMD_SUSPEND: begin
					if (st.op == FWP_OP_PROGRAM && !st.suspended) begin
						next_st.suspended = 1'b1;
						next_st.func[FN_PROGRAM_SUSPENDED_FLAG] = 1'b1;
					end else if (st.op == FWP_OP_ERASE && !st.suspended) begin
						next_st.suspended = 1'b1;
						next_st.func[FN_ERASE_SUSPENDED_FLAG] = 1'b1;
					end
				end
				CMD_RESUME: begin
					if (st.suspended) begin
						next_st.suspended = 1'b0;
						next_st.func[FN_PROGRAM_SUSPENDED_FLAG] = 1'b0;
						next_st.func[FN_ERASE_SUSPENDED_FLAG] = 1'b0;
					end
				end
				default: begin
					// Write commands need an idle array and the latch set.
					if (st.op == FWP_OP_NONE && write_enable_latch) begin
						if (st.cmd == CMD_STATUS_WRITE && st.nbytes >= 3'd2) begin
							if (!st.status[ST_STATUS_WRITE_DISABLE] || wp_high) begin
								next_st.status = (st.data & STATUS_NV_MASK)
									| (st.status & ~STATUS_NV_MASK);
								next_st.op = FWP_OP_REGISTER;
								next_st.cnt = OP_LAST;
							end
						end else if (st.cmd == CMD_FUNCTION_WRITE && st.nbytes >= 3'd2) begin
							newf = st.func | (st.data & FUNCTION_OTP_MASK);
							next_st.func = newf;
							next_st.op = FWP_OP_REGISTER;
							next_st.cnt = OP_LAST;
						end else if ((st.cmd == CMD_CHIP_ERASE_A || st.cmd == CMD_CHIP_ERASE_B)
							&& bp == 4'h0) begin
							next_st.op = FWP_OP_ERASE;
							next_st.chip = 1'b1;
							next_st.start = 1'b1;
							next_st.cnt = OP_LAST;
						end else if (is_addr_cmd(st.cmd) && st.nbytes >= 3'd4) begin
							if (st.cmd == CMD_INFO_ROW_PROGRAM || st.cmd == CMD_INFO_ROW_ERASE) begin
								if (!(st.cmd == CMD_INFO_ROW_PROGRAM
									&& st.func[FN_IRL_LO + int'(row)])) begin
									next_st.op = (st.cmd == CMD_INFO_ROW_PROGRAM)
										? FWP_OP_PROGRAM : FWP_OP_ERASE;
									next_st.chip = 1'b0;
									next_st.start = 1'b1;
									next_st.cnt = OP_LAST;
								end
							end else if (!block_protected(bp, st.func[FN_TBS], st.addr)) begin
								next_st.op = (st.cmd == CMD_PAGE_PROGRAM
									|| st.cmd == CMD_QUAD_PROGRAM_A
									|| st.cmd == CMD_QUAD_PROGRAM_B)
									? FWP_OP_PROGRAM : FWP_OP_ERASE;
								next_st.chip = 1'b0;
								next_st.start = 1'b1;
								next_st.cnt = OP_LAST;
							end
						end
					end
				end
			endcase
		end
		next_st.status[ST_BUSY] = (next_st.op != FWP_OP_NONE) && !next_st.suspended;
	end

	// ----------------------------------------------------------------
	// Registers; non-volatile images power up at their factory value.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{wp_s: 2'b00, hold_s: 2'b11, status: REG_RESET, func: REG_RESET,
				cmd: 8'h00, nbytes: 3'd0, addr: '0, data: 8'h00, op: FWP_OP_NONE,
				cnt: '0, suspended: 1'b0, start: 1'b0, chip: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs; reads return the status or function image.
	// ----------------------------------------------------------------
	// Opcode that selects the reply: the byte just taken when it is the first
	// of the frame, otherwise the opcode already stored for this frame.
	logic [7:0] read_cmd;
	assign read_cmd = (link.byte_valid && st.nbytes == 3'd0) ? link.byte_data : st.cmd;
	assign link.out_byte = (read_cmd == CMD_READ_FUNCTION) ? st.func : st.status;
	assign quad_mode_o = st.status[ST_QE];
	// With quad mode on, the shared pins carry data and hold is ignored.
	assign hold_active_o = !st.status[ST_QE] && !st.hold_s[1];
	assign busy_o = st.status[ST_BUSY];
	assign status_o = st.status;
	assign function_config_register_o = st.func;
	assign array_start_o = st.start;
	assign array_op_o = st.op;
	assign array_addr_o = st.addr;
	assign array_chip_o = st.chip;

endmodule
`default_nettype wire

/* File: testbench/fwp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host controller: serial clock stands low between frames, 48 ns period.
module fwp_host_model (
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// Shifts n bytes MSB first; rd keeps the last eight bits seen on so.
	task automatic frame(input int n, input logic [31:0] d, output logic [7:0] rd);
		rd = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 0; i < n * 8; i++) begin
			si_o = d[31-i];
			#24 sck_o = 1'b1;
			rd = {rd[6:0], so_i};
			#24 sck_o = 1'b0;
		end
		#24 cs_n_o = 1'b1;
		// A released line must not keep looking like valid data.
		si_o = ~si_o;
		#100;
	endtask
endmodule
`default_nettype wire

/* File: testbench/fwp_protect_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module fwp_protect_bench;
	import fwp_pkg::*;
	localparam int OPC = 300;
	logic clk_sys_i, rst_n_i, sck, cs_n, si, so, wp, hold, quad, hold_act, busy, start, chip;
	logic [7:0] st, fn, rd;
	logic [ADDR_W-1:0] addr;
	fwp_op_t op;
	logic [31:0] seed = 32'hf869_4794;
	logic [31:0] exp_q [$]; // Expected starts: op, chip flag, address.
	logic [7:0] cmds [7] = '{CMD_PAGE_PROGRAM, CMD_QUAD_PROGRAM_A, CMD_QUAD_PROGRAM_B,
		CMD_SECTOR_ERASE_A, CMD_SECTOR_ERASE_B, CMD_BLOCK_ERASE_32K, CMD_BLOCK_ERASE_64K};
	int fail_count = 0;
	int comparisons = 0;
	fwp_protect #(.BLOCKS(128), .OP_CYCLES_P(OPC)) fwp_protect_i (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .wp_pin_i(wp),
		.hold_pin_i(hold), .quad_mode_o(quad), .hold_active_o(hold_act), .busy_o(busy),
		.status_o(st), .function_config_register_o(fn), .array_start_o(start),
		.array_op_o(op), .array_addr_o(addr), .array_chip_o(chip));
	fwp_host_model fwp_host_model_i (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Each array start takes the oldest note; a start nobody expected is a fault.
	always @(negedge clk_sys_i) begin
		if (start === 1'b1 && op !== FWP_OP_REGISTER) begin
			if (exp_q.size() == 0) begin
				check(1, 0);
			end else begin
				check({5'h0, op, chip, chip ? 24'h0 : addr}, exp_q.pop_front());
			end
		end
	end
	function automatic fwp_op_t kind(input logic [7:0] c);
		return (c == CMD_PAGE_PROGRAM || c[7:4] == 4'h3) ? FWP_OP_PROGRAM : FWP_OP_ERASE;
	endfunction
	task automatic send(input int n, input logic [31:0] d);
		fwp_host_model_i.frame(n, d, rd);
		repeat (10) @(negedge clk_sys_i);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 2000) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (k == 2000) begin
			check(0, 1);
			finish_test();
		end
	endtask
	// Latch, then one write command; refused ones must leave the latch set.
	task automatic wr_cmd(input int n, input logic [31:0] d, input logic acc, input logic [31:0] e);
		send(1, {CMD_WRITE_ENABLE, 24'h0});
		check(st[ST_WEL], 1'b1);
		if (acc && e != 0) exp_q.push_back(e);
		send(n, d);
		check(exp_q.size(), 0);
		if (acc) begin
			wait_idle();
			check(st[ST_WEL], 1'b0);
		end else begin
			check({busy, st[ST_WEL]}, 2'b01);
			send(1, {CMD_WRITE_DISABLE, 24'h0});
			check(st[ST_WEL], 1'b0);
		end
	endtask
	// Walks protect codes, probing the protected and free blocks on either side of the boundary.
	task automatic sweep(input logic bottom);
		logic [3:0] code;
		int cnt;
		logic [6:0] blk;
		logic [23:0] a;
		for (int c = 0; c < 10; c++) begin
			code = (c == 9) ? 4'(8 + ($random(seed) & 7)) : 4'(c);
			cnt = code[3] ? 128 : ((code == 0) ? 0 : (1 << (code - 1)));
			wr_cmd(2, {CMD_STATUS_WRITE, 2'b00, code, 18'h0}, 1'b1, 0);
			check(st, {2'b00, code, 2'b00});
			a = {1'b0, 7'h0, 16'($random(seed))};
			if (cnt > 0) begin
				blk = bottom ? 7'(cnt - 1) : 7'(128 - cnt);
				wr_cmd(4, {cmds[c % 7], 1'b0, blk, a[15:0]}, 1'b0, 0);
			end
			if (cnt < 128) begin
				blk = bottom ? 7'(cnt) : 7'(127 - cnt);
				a[22:16] = blk;
				wr_cmd(4, {cmds[(c + 3) % 7], a}, 1'b1, {5'h0, kind(cmds[(c + 3) % 7]), 1'b0, a});
			end
			wr_cmd(1, {c[0] ? CMD_CHIP_ERASE_B : CMD_CHIP_ERASE_A, 24'h0}, code == 4'h0,
				{5'h0, FWP_OP_ERASE, 1'b1, 24'h0});
		end
	endtask
	initial begin
		rst_n_i = 1'b0;
		wp = 1'b0;
		hold = 1'b0;
		repeat (20) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		repeat (10) @(negedge clk_sys_i);
		check({st, fn, hold_act}, 17'h0_0001);
		hold = 1'b1;
		sweep(1'b0);
		wr_cmd(2, {CMD_STATUS_WRITE, 24'h0}, 1'b1, 0);
		wr_cmd(2, {CMD_FUNCTION_WRITE, 8'h1f, 16'h0}, 1'b1, 0);
		check(fn, 8'h12);
		wr_cmd(2, {CMD_FUNCTION_WRITE, 8'h20, 16'h0}, 1'b1, 0);
		check(fn, 8'h32);
		wr_cmd(4, {CMD_INFO_ROW_PROGRAM, 24'h00_1010}, 1'b0, 0);
		wr_cmd(4, {CMD_INFO_ROW_PROGRAM, 24'h00_2020}, 1'b1,
			{5'h0, FWP_OP_PROGRAM, 1'b0, 24'h00_2020});
		wr_cmd(4, {CMD_INFO_ROW_ERASE, 24'h0}, 1'b1, {5'h0, FWP_OP_ERASE, 1'b0, 24'h0});
		for (int k = 0; k < 2; k++) begin
			send(1, {CMD_WRITE_ENABLE, 24'h0});
			exp_q.push_back({5'h0, k ? FWP_OP_ERASE : FWP_OP_PROGRAM, 1'b0, 24'h10_0000});
			send(4, {k ? CMD_SECTOR_ERASE_B : CMD_QUAD_PROGRAM_B, 24'h10_0000});
			send(1, {CMD_SUSPEND, 24'h0});
			check(fn[FN_PROGRAM_SUSPENDED_FLAG+k], 1'b1);
			send(1, {CMD_RESUME, 24'h0});
			check(fn[3:2], 2'b00);
			wait_idle();
		end
		sweep(1'b1);
		wr_cmd(2, {CMD_STATUS_WRITE, 8'h80, 16'h0}, 1'b1, 0);
		wr_cmd(2, {CMD_STATUS_WRITE, 8'h40, 16'h0}, 1'b0, 0);
		check(st, 8'h80);
		wp = 1'b1;
		wr_cmd(2, {CMD_STATUS_WRITE, 8'h40, 16'h0}, 1'b1, 0);
		hold = 1'b0;
		send(2, {CMD_READ_STATUS, 24'h0});
		check({quad, hold_act, rd}, 10'h240);
		send(2, {CMD_READ_FUNCTION, 24'h0});
		check(rd, 8'h32);
		check(exp_q.size(), 0);
		finish_test();
	end
endmodule
`default_nettype wire

/* File: testbench/fwp_protect_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches the protection core from its pins only.
module fwp_protect_chk
	import fwp_pkg::*;
#(
	parameter int BLOCKS = BLOCKS_DEFAULT,
	parameter int OP_CYCLES_P = OP_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic so_o,
	input wire logic wp_pin_i,
	input wire logic hold_pin_i,
	input wire logic quad_mode_o,
	input wire logic hold_active_o,
	input wire logic busy_o,
	input wire logic [7:0] status_o,
	input wire logic [7:0] function_config_register_o,
	input wire logic array_start_o,
	input wire fwp_op_t array_op_o,
	input wire logic [ADDR_W-1:0] array_addr_o,
	input wire logic array_chip_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// A start pulse lasts one cycle and is followed by busy soon after.
	a_start_one_cycle: assert property (array_start_o |=> !array_start_o)
		else $error("start pulse longer than one cycle");
	a_start_sets_busy: assert property (array_start_o |-> ##[0:2] busy_o)
		else $error("start without busy");
	a_start_needs_latch: assert property (array_start_o |-> $past(status_o[ST_WEL]))
		else $error("operation started with latch clear");
	a_chip_needs_clear: assert property (array_start_o && array_chip_o |-> status_o[5:2] == 4'h0)
		else $error("chip erase with protect bits set");
	a_quad_on_write: assert property (!$stable(quad_mode_o) |-> busy_o)
		else $error("quad mode changed outside a status write");
	a_hold_only_spi: assert property (hold_active_o |-> !quad_mode_o && !$past(hold_pin_i, 2))
		else $error("hold active in quad mode or with pin high");
	a_bottom_sticky: assert property ($past(function_config_register_o[FN_TBS])
		|-> function_config_register_o[FN_TBS])
		else $error("bottom select returned to top");
	a_locks_sticky: assert property (($past(function_config_register_o[7:4])
		& ~function_config_register_o[7:4]) == 4'h0)
		else $error("one-time lock bit cleared");
	// Non-volatile bits may only move around a status write, which is busy.
	a_nv_only_write: assert property (!$stable(status_o[7:2]) |-> busy_o || $past(busy_o))
		else $error("protect bits changed outside a write");
	a_latch_auto_clear: assert property ($fell(busy_o) |-> ##2
		(!status_o[ST_WEL] || function_config_register_o[3:2] != 2'b00))
		else $error("latch still set after write completed");
endmodule
bind fwp_protect fwp_protect_chk #(.BLOCKS(BLOCKS), .OP_CYCLES_P(OP_CYCLES_P)) fwp_protect_chk_i (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
	.so_o(so_o), .wp_pin_i(wp_pin_i), .hold_pin_i(hold_pin_i), .quad_mode_o(quad_mode_o),
	.hold_active_o(hold_active_o), .busy_o(busy_o), .status_o(status_o),
	.function_config_register_o(function_config_register_o), .array_start_o(array_start_o),
	.array_op_o(array_op_o), .array_addr_o(array_addr_o), .array_chip_o(array_chip_o)
);
`default_nettype wire
